/* logic/rcr_pkg.sv */
/*
 * Shared constants, types and the voltage-code decode for the four
 * regulator control registers (regulators six to nine).
 * Assumes a single system clock and one register access port fed by the
 * serial control interface's protocol engine.
 */
`default_nettype none

package rcr_pkg;

    // Number of regulators served by this bank.
    localparam int RCR_NUM_RAILS = 4;

    // Register addresses on the serial control interface.
    localparam logic [7:0] RCR_ADDR_REG6 = 8'h1d;
    localparam logic [7:0] RCR_ADDR_REG7 = 8'h1e;
    localparam logic [7:0] RCR_ADDR_REG8 = 8'h1f;
    localparam logic [7:0] RCR_ADDR_REG9 = 8'h20;

    // Field positions inside each 8-bit control register.
    localparam int RCR_BIT_ENABLE = 7;
    localparam int RCR_BIT_LOW_POWER = 6;
    localparam int RCR_VSEL_MSB = 5;
    localparam int RCR_VSEL_LSB = 0;

    // Reset values held while reset is asserted, and the power-save value written when the defaults load.
    localparam logic [7:0] RCR_CTRL_CLEAR = 8'h00;
    localparam logic RCR_LOW_POWER_DEFAULT = 1'b0;
    localparam logic [7:0] RCR_RD_IDLE = 8'h00;

    // Voltage-code decode, in millivolts.
    localparam logic [11:0] RCR_MV_LOW_BASE = 12'h320;
    localparam logic [11:0] RCR_MV_LOW_STEP = 12'h019;
    localparam logic [11:0] RCR_MV_HIGH_BASE = 12'h640;
    localparam logic [11:0] RCR_MV_HIGH_STEP = 12'h032;
    localparam logic [5:0] RCR_CODE_TOP_START = 6'h3d;
    localparam logic [11:0] RCR_MV_TOP_BASE = 12'hc1c;
    localparam logic [11:0] RCR_MV_TOP_STEP = 12'h064;

    // Default of one regulator as programmed in one-time memory.
    typedef struct packed {
        logic enable;
        logic sequenced;
        logic [5:0] vsel;
    } rcr_otp_t;

    // Control state presented to one analog regulator.
    typedef struct packed {
        logic on;
        logic low_power;
        logic [5:0] vsel;
        logic [11:0] mv;
    } rcr_rail_t;

    // Bank state: load defaults once after reset, then serve the host.
    typedef enum logic [1:0] {
        RCR_ST_LOAD = 2'b01,
        RCR_ST_RUN = 2'b10
    } rcr_state_t;

    // Translates a six-bit voltage code into the output voltage in millivolts.
    function automatic logic [11:0] rcr_vsel_to_mv(input logic [5:0] code);
        logic [11:0] span;
        span = {7'h00, code[4:0]};
        if (!code[5]) begin
            rcr_vsel_to_mv = RCR_MV_LOW_BASE + span * RCR_MV_LOW_STEP;
        end else if (code < RCR_CODE_TOP_START) begin
            rcr_vsel_to_mv = RCR_MV_HIGH_BASE + span * RCR_MV_HIGH_STEP;
        end else begin
            rcr_vsel_to_mv = RCR_MV_TOP_BASE + {6'h00, code - RCR_CODE_TOP_START} * RCR_MV_TOP_STEP;
        end
    endfunction

endpackage

`default_nettype wire

/* logic/rcr_reg_slot.sv */
/*
 * One regulator control register with its power-up sequencing flag.
 * Assumes the load strobe arrives once after power-on reset and that the
 * sequencer's step pulse is synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module rcr_reg_slot
    import rcr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic load,
    input wire rcr_otp_t otp,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic seq_step,
    output logic [7:0] ctrl_r,
    output logic pending_r
);

    // Register content: defaults at load, host data on write.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= RCR_CTRL_CLEAR;
        end else if (load) begin
            ctrl_r[RCR_BIT_ENABLE] <= otp.enable | otp.sequenced;
            ctrl_r[RCR_BIT_LOW_POWER] <= RCR_LOW_POWER_DEFAULT;
            ctrl_r[RCR_VSEL_MSB:RCR_VSEL_LSB] <= otp.vsel;
        end else if (wr_en) begin
            ctrl_r <= wr_data;
        end
    end

    // A sequenced enable waits for its sequencer step; a host write takes over.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pending_r <= 1'b0;
        end else if (load) begin
            pending_r <= otp.sequenced;
        end else if (seq_step || wr_en) begin
            pending_r <= 1'b0;
        end
    end

endmodule // rcr_reg_slot

`default_nettype wire

/* logic/rcr_top.sv */
/*
 * Control register bank for linear regulators six to nine: enable,
 * power-save select and voltage code per regulator, with defaults loaded
 * from one-time memory after power-on reset.
 * Each register holds an enable bit, a power-save bit and a six-bit voltage
 * code; the bank drives one control word per regulator to the analog side.
 * Register port timing: a strobe taken at a rising edge is answered by a
 * one-cycle valid or acknowledge pulse at the next edge, and written values
 * reach the regulator outputs one edge after that.
 * Strobes in the single load cycle after reset are dropped, so the host must
 * wait one cycle after reset release before its first access.
 * A read and a write to the same register in one cycle return the old value,
 * since the read multiplexer sits in front of the slot registers.
 * Unmapped reads return zero with a valid pulse but no acknowledge.
 * The decoded millivolt value on each rail output is for the analog trim
 * and for observation; the voltage code itself is passed through unchanged.
 * Assumes a protocol engine on clk_sys that presents byte reads and writes
 * on the register port, a sequencer on clk_sys that pulses one step line per
 * regulator, and one-time memory outputs that are stable after reset.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Bit 7 turns the regulator on when 1, keeps it off when 0.
// - A sequenced enable default turns the regulator on at its power-up step.
// - Bit 6 selects power save mode when 1, normal mode when 0.
// - Bits 5 to 0 hold the six-bit output voltage code.
// - Power-on reset reloads one-time defaults; power save defaults to 0.
// - Codes decode to 0.8 to 1.575 V, 1.6 to 3.0 V, then 3.1-3.3 V.
module rcr_top
    import rcr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire rcr_otp_t [RCR_NUM_RAILS-1:0] otp_default,
    input wire logic [RCR_NUM_RAILS-1:0] seq_step,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data_r,
    output logic reg_rd_valid_r,
    output logic reg_ack_r,
    output rcr_rail_t [RCR_NUM_RAILS-1:0] rail_r,
    output logic defaults_loaded_r
);

    rcr_state_t state_r;
    rcr_state_t state_nxt;
    logic load;
    logic running;
    logic [RCR_NUM_RAILS-1:0] addr_hit;
    logic any_hit;
    logic [7:0] rd_mux;
    logic [7:0] ctrl [RCR_NUM_RAILS];
    logic [RCR_NUM_RAILS-1:0] pending;
    logic [7:0] rail_addr [RCR_NUM_RAILS];
    logic [RCR_NUM_RAILS-1:0] slot_wr;
    logic [RCR_NUM_RAILS-1:0] slot_step;
    logic rd_take;
    logic acc_take;

    // Address of each regulator's control register, in bank order.
    assign rail_addr[0] = RCR_ADDR_REG6;
    assign rail_addr[1] = RCR_ADDR_REG7;
    assign rail_addr[2] = RCR_ADDR_REG8;
    assign rail_addr[3] = RCR_ADDR_REG9;

    // Next state: one load cycle after reset release, then serve forever.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RCR_ST_LOAD: begin
                state_nxt = RCR_ST_RUN;
            end
            RCR_ST_RUN: begin
                state_nxt = RCR_ST_RUN;
            end
            default: begin
                state_nxt = RCR_ST_LOAD;
            end
        endcase
    end

    // State register; power-on reset always restarts the default load.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= RCR_ST_LOAD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Defaults are sampled by a clocked load, never through the async reset.
    assign load = (state_r == RCR_ST_LOAD);
    assign running = (state_r == RCR_ST_RUN);

    // Address decode over the four control registers.
    always_comb begin
        addr_hit = '0;
        for (int i = 0; i < RCR_NUM_RAILS; i++) begin
            addr_hit[i] = (reg_addr == rail_addr[i]);
        end
    end

    // Access qualifiers; nothing is taken before the defaults are in place.
    assign any_hit = |addr_hit;
    assign rd_take = reg_rd_en && running;
    assign acc_take = running && any_hit && (reg_wr_en || reg_rd_en);

    // Per-slot write and sequencer strobes, gated off in the load cycle.
    always_comb begin
        slot_wr = '0;
        slot_step = '0;
        for (int i = 0; i < RCR_NUM_RAILS; i++) begin
            slot_wr[i] = running && reg_wr_en && addr_hit[i];
            slot_step[i] = running && seq_step[i];
        end
    end

    // Read data selection; addresses outside this bank read as zero.
    always_comb begin
        rd_mux = RCR_RD_IDLE;
        for (int i = 0; i < RCR_NUM_RAILS; i++) begin
            if (addr_hit[i]) begin
                rd_mux = ctrl[i];
            end
        end
    end

    // One register slot per regulator.
    for (genvar g = 0; g < RCR_NUM_RAILS; g++) begin : g_slot
        rcr_reg_slot u_slot (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .load(load),
            .otp(otp_default[g]),
            .wr_en(slot_wr[g]),
            .wr_data(reg_wr_data),
            .seq_step(slot_step[g]),
            .ctrl_r(ctrl[g]),
            .pending_r(pending[g])
        );
    end

    // Registered read answer, one cycle after the strobe.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data_r <= RCR_RD_IDLE;
        end else if (rd_take) begin
            reg_rd_data_r <= rd_mux;
        end
    end

    // Read valid pulse; strobes during the load cycle are not answered.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_valid_r <= 1'b0;
        end else begin
            reg_rd_valid_r <= rd_take;
        end
    end

    // Acknowledge pulse for any access that landed on a bank register.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_ack_r <= 1'b0;
        end else begin
            reg_ack_r <= acc_take;
        end
    end

    // Marks that the one-time defaults are in place.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            defaults_loaded_r <= 1'b0;
        end else if (load) begin
            defaults_loaded_r <= 1'b1;
        end
    end

    // Regulator controls, one flop group per regulator and per field.
    for (genvar g = 0; g < RCR_NUM_RAILS; g++) begin : g_rail
        // Switch; a sequenced enable holds the regulator off until its step.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                rail_r[g].on <= '0;
            end else begin
                rail_r[g].on <= ctrl[g][RCR_BIT_ENABLE] & ~pending[g];
            end
        end

        // Operating mode: power save while the mode bit is set.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                rail_r[g].low_power <= '0;
            end else begin
                rail_r[g].low_power <= ctrl[g][RCR_BIT_LOW_POWER];
            end
        end

        // Six-bit voltage code, passed through to the analog side.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                rail_r[g].vsel <= '0;
            end else begin
                rail_r[g].vsel <= ctrl[g][RCR_VSEL_MSB:RCR_VSEL_LSB];
            end
        end

        // Decoded output voltage in millivolts.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                rail_r[g].mv <= '0;
            end else begin
                rail_r[g].mv <= rcr_vsel_to_mv(ctrl[g][RCR_VSEL_MSB:RCR_VSEL_LSB]);
            end
        end
    end

endmodule // rcr_top

`default_nettype wire

/* tb/rcr_top_asserts.sv */
/* Assertions on the ports of the regulator control register bank.
   Assumes it is bound to rcr_top from the testbench top file. */
`timescale 1ns/1ps
`default_nettype none
module rcr_top_asserts
    import rcr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic reg_rd_valid_r,
    input wire logic reg_ack_r,
    input wire rcr_rail_t [RCR_NUM_RAILS-1:0] rail_r,
    input wire logic defaults_loaded_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Expected millivolts for a voltage code.
    function automatic logic [11:0] mv_of(input logic [5:0] c);
        if (c < 6'h20) return 12'h320 + 12'(c) * 12'h019;
        if (c < 6'h3d) return 12'h640 + 12'(c - 6'h20) * 12'h032;
        return 12'hc1c + 12'(c - 6'h3d) * 12'h064;
    endfunction
    // Accepted accesses: any mapped one, and writes to regulator six.
    logic hit;
    logic wr6;
    assign hit = defaults_loaded_r && (reg_rd_en || reg_wr_en) && reg_addr >= 8'h1d && reg_addr <= 8'h20;
    assign wr6 = defaults_loaded_r && reg_wr_en && reg_addr == 8'h1d;
    property p_rd_valid; reg_rd_en && defaults_loaded_r |=> reg_rd_valid_r; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_ack; hit |=> reg_ack_r; endproperty
    a_ack: assert property (p_ack) else $error("mapped access not acknowledged");
    property p_no_ack; !hit |=> !reg_ack_r; endproperty
    a_no_ack: assert property (p_no_ack) else $error("acknowledge without mapped access");
    property p_on; wr6 |-> ##2 rail_r[0].on == $past(reg_wr_data[7], 2); endproperty
    a_on: assert property (p_on) else $error("enable not applied");
    property p_low_power; wr6 |-> ##2 rail_r[0].low_power == $past(reg_wr_data[6], 2); endproperty
    a_low_power: assert property (p_low_power) else $error("power save not applied");
    property p_vsel; wr6 |-> ##2 rail_r[0].vsel == $past(reg_wr_data[5:0], 2); endproperty
    a_vsel: assert property (p_vsel) else $error("voltage code not applied");
    property p_mv; defaults_loaded_r && $past(defaults_loaded_r) |-> rail_r[0].mv == mv_of(rail_r[0].vsel); endproperty
    a_mv: assert property (p_mv) else $error("voltage decode wrong");
    property p_lp_default; $rose(defaults_loaded_r) |=> !(rail_r[0].low_power || rail_r[3].low_power); endproperty
    a_lp_default: assert property (p_lp_default) else $error("power save default not 0");
    property p_loaded; defaults_loaded_r |=> defaults_loaded_r; endproperty
    a_loaded: assert property (p_loaded) else $error("defaults flag dropped");
endmodule // rcr_top_asserts
`default_nettype wire

/* tb/test_rcr_top.sv */
/* Self-checking bench for rcr_top: defaults, sequencing, write and read back, decode, unmapped access.
   Assumes the bench drives every input; the checker is bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module test_rcr_top
    import rcr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    rcr_otp_t [RCR_NUM_RAILS-1:0] otp_default = 32'h2579bc24;
    logic [RCR_NUM_RAILS-1:0] seq_step = 4'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_rd_data_r;
    logic reg_rd_valid_r;
    logic reg_ack_r;
    logic defaults_loaded_r;
    rcr_rail_t [RCR_NUM_RAILS-1:0] rail_r;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [7:0] rd;
    logic [7:0] wv [8] = '{8'ha5, 8'h5f, 8'h3c, 8'hff, 8'h20, 8'h3d, 8'h00, 8'h1f};
    logic [11:0] wmv [8] = '{12'h73a, 12'h627, 12'hbb8, 12'hce4, 12'h640, 12'hc1c, 12'h320, 12'h627};
    // The clock toggles every 10 ns, a period of 20 ns.
    always #10 clk_sys = ~clk_sys;
    rcr_top u_dut (.clk_sys, .reset_n, .otp_default, .seq_step, .reg_addr, .reg_wr_en, .reg_wr_data,
        .reg_rd_en, .reg_rd_data_r, .reg_rd_valid_r, .reg_ack_r, .rail_r, .defaults_loaded_r);
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One register access; the answer is sampled in the cycle after it is taken.
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic ack);
        @(posedge clk_sys);
        reg_wr_en <= wr;
        reg_rd_en <= !wr;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        #1;
        chk("ack", 20'(ack), 20'(reg_ack_r));
        chk("valid", 20'(!wr), 20'(reg_rd_valid_r));
        rd = reg_rd_data_r;
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_defaults();
        logic [7:0] exp [4] = '{8'h24, 8'hbc, 8'hb9, 8'h25};
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 8'h1d + 8'(i), 8'h00, 1'b1);
            chk("default", 20'(exp[i]), 20'(rd));
        end
        chk("on7", 20'h1, 20'(rail_r[1].on));
        chk("on8 waits", 20'h0, 20'(rail_r[2].on));
        chk("loaded", 20'h1, 20'(defaults_loaded_r));
        @(posedge clk_sys);
        seq_step <= 4'h4;
        @(posedge clk_sys);
        seq_step <= 4'h0;
        #1;
        chk("on8 before step", 20'h0, 20'(rail_r[2].on));
        @(posedge clk_sys);
        #1;
        chk("on8 stepped", 20'h1, 20'(rail_r[2].on));
    endtask
    task automatic t_write_read();
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, 8'h1d + 8'(i % 4), wv[i], 1'b1);
            acc(1'b0, 8'h1d + 8'(i % 4), 8'h00, 1'b1);
            chk("readback", 20'(wv[i]), 20'(rd));
            chk("rail", {wv[i], wmv[i]}, rail_r[i % 4]);
        end
    endtask
    task automatic t_unmapped();
        acc(1'b1, 8'h21, 8'hff, 1'b0);
        acc(1'b0, 8'h21, 8'h00, 1'b0);
        chk("unmapped", 20'h0, 20'(rd));
        acc(1'b0, 8'h20, 8'h00, 1'b1);
        chk("kept", 20'h1f, 20'(rd));
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A hang is cut short at 1 ms, far above the 78 clock cycles the test needs.
    initial begin
        #1ms;
        n_mismatch++;
        finish_test();
    end
    // Main sequence, with a second reset to show the defaults return.
    initial begin
        do_reset();
        t_defaults();
        t_write_read();
        t_unmapped();
        do_reset();
        t_defaults();
        finish_test();
    end
endmodule // test_rcr_top
bind rcr_top rcr_top_asserts u_chk (.clk_sys, .reset_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
    .reg_rd_valid_r, .reg_ack_r, .rail_r, .defaults_loaded_r);
`default_nettype wire
